// file: include/flash_wp_pkg.sv
package flash_wp_pkg;

	// Instruction codes
	localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
	localparam logic [7:0] CMD_PAGE_PROGRAM   = 8'h02;
	localparam logic [7:0] CMD_QUAD_PROGRAM   = 8'h32;
	localparam logic [7:0] CMD_SECTOR_ERASE   = 8'h20;
	localparam logic [7:0] CMD_BLOCK32_ERASE  = 8'h52;
	localparam logic [7:0] CMD_BLOCK64_ERASE  = 8'hd8;
	localparam logic [7:0] CMD_CHIP_ERASE     = 8'hc7;
	localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'h60;
	localparam logic [7:0] CMD_WRITE_STATUS1  = 8'h01;
	localparam logic [7:0] CMD_WRITE_STATUS2  = 8'h31;
	localparam logic [7:0] CMD_READ_STATUS1   = 8'h05;
	localparam logic [7:0] CMD_READ_STATUS2   = 8'h35;
	localparam logic [7:0] CMD_POWER_DOWN     = 8'hb9;
	localparam logic [7:0] CMD_RELEASE_PD     = 8'hab;
	localparam logic [7:0] CMD_UNLOCK         = 8'h39;
	localparam logic [7:0] CMD_SECREG_ERASE   = 8'h44;
	localparam logic [7:0] CMD_SECREG_PROGRAM = 8'h42;
	localparam logic [7:0] CMD_OTP_KEY1       = 8'haa;
	localparam logic [7:0] CMD_OTP_KEY2       = 8'h55;

	// Status register one fields
	localparam int BUSY_BIT = 0;
	localparam int WEL_BIT  = 1;
	localparam int BP_LSB   = 2;
	localparam int BP_W     = 3;
	localparam int TB_BIT   = 5;
	localparam int SEC_BIT  = 6;
	localparam int SRP_BIT  = 7;
	// Status register two fields
	localparam int SRL_BIT  = 0;
	localparam int QE_BIT   = 1;
	localparam int CMP_BIT  = 6;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Frame lengths in bytes, opcode included
	localparam logic [2:0] LEN_CMD       = 3'h1;
	localparam logic [2:0] LEN_ONE_DATA  = 3'h2;
	localparam logic [2:0] LEN_TWO_DATA  = 3'h3;
	localparam logic [2:0] LEN_ADDR      = 3'h4;
	localparam logic [2:0] LEN_PROG_MIN  = 3'h5;
	localparam logic [2:0] LEN_SAT       = 3'h7;
	localparam logic [2:0] LAST_BIT      = 3'h7;
	localparam int BYTE_W = 8;
	localparam int ARG_W  = 24;

	// Array geometry
	localparam int LOCK_BLOCKS  = 126;
	localparam int EDGE_SECTORS = 16;
	localparam int SECTOR_LOCKS = 32;
	localparam int SECTOR_SHIFT = 12;
	localparam int BLOCK_SHIFT  = 16;
	localparam int BLK_W        = $clog2(LOCK_BLOCKS + 2);
	localparam int ADDR_W       = BLOCK_SHIFT + BLK_W;
	localparam logic [BP_W-1:0] BP_NONE    = 3'h0;
	localparam logic [BP_W-1:0] BP_ALL     = 3'h7;
	localparam logic [BP_W-1:0] BP_SEC_CAP = 3'h4;

	localparam int CLK_MHZ = 25;
	localparam int CNT_W   = 32;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_PROGRAM,
		OP_SECTOR_ERASE,
		OP_BLOCK_ERASE,
		OP_CHIP_ERASE,
		OP_STATUS_WRITE,
		OP_SECREG
	} array_kind_type;

	typedef struct packed {
		array_kind_type    kind;
		logic [ADDR_W-1:0] addr;
	} array_op_type;

	typedef struct packed {
		logic              start;
		logic              stop;
		logic              byte_valid;
		logic [BYTE_W-1:0] data;
	} frame_event_type;

endpackage

// file: testbench/flash_wp_checker.sv
`timescale 1ns/100ps
`default_nettype none
module flash_wp_checker
	import flash_wp_pkg::*;
#(
	parameter int POWERUP_DELAY_US = 5000
) (
	input wire logic                       clk,
	input wire logic                       sys_rst,
	input wire logic                       power_good,
	input wire logic                       write_guard_n,
	input wire flash_wp_pkg::array_op_type array_op,
	input wire logic                       array_op_valid,
	input wire logic [7:0]                 status_one,
	input wire logic [7:0]                 status_two
);
	logic [31:0] pg_cnt_q;
	logic [7:0]  guard_low_q;
	// Counts from the pin, so it runs ahead of the synced window
	always_ff @(posedge clk) begin
		if (sys_rst || !power_good)
			pg_cnt_q <= '0;
		else if (pg_cnt_q != '1)
			pg_cnt_q <= pg_cnt_q + 32'h1;
	end
	always_ff @(posedge clk) begin
		if (sys_rst || write_guard_n)
			guard_low_q <= '0;
		else if (guard_low_q != '1)
			guard_low_q <= guard_low_q + 8'h01;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	op_busy_a: assert property (array_op_valid |-> status_one[BUSY_BIT])
		else $error("operation without busy");
	op_wel_a: assert property (array_op_valid |-> $past(status_one[WEL_BIT]))
		else $error("operation without latch");
	wel_clear_a: assert property ($fell(status_one[BUSY_BIT]) |-> !status_one[WEL_BIT])
		else $error("latch kept after operation");
	busy_hold_a: assert property ($rose(status_one[BUSY_BIT]) |=> status_one[BUSY_BIT] [*8])
		else $error("busy dropped early");
	busy_ignore_a: assert property (status_one[BUSY_BIT] && $past(status_one[BUSY_BIT]) |-> !array_op_valid)
		else $error("operation taken while busy");
	pup_window_a: assert property (array_op_valid |-> pg_cnt_q > POWERUP_DELAY_US * CLK_MHZ)
		else $error("operation inside power-up window");
	pg_reset_a: assert property (!power_good [*4] |-> status_one[WEL_BIT:BUSY_BIT] == 2'b00)
		else $error("state kept without supply");
	guard_refuse_a: assert property (array_op_valid && array_op.kind == OP_STATUS_WRITE && guard_low_q > 8'h08
		&& $past(status_one[SRP_BIT], 3) |-> $past(status_two[QE_BIT], 3))
		else $error("status write with guard low");
	lock_refuse_a: assert property (array_op_valid && array_op.kind == OP_STATUS_WRITE
		|-> !$past(status_two[SRL_BIT], 3))
		else $error("status write while locked");
	cover property (array_op_valid && array_op.kind == OP_SECTOR_ERASE);
	cover property ($fell(status_one[BUSY_BIT]));
	cover property (status_two[SRL_BIT] && !power_good);
endmodule
bind serial_flash_write_protect flash_wp_checker #(.POWERUP_DELAY_US(POWERUP_DELAY_US)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .power_good(power_good), .write_guard_n(write_guard_n),
	.array_op(array_op), .array_op_valid(array_op_valid), .status_one(status_one), .status_two(status_two));
`default_nettype wire

// file: testbench/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input  wire logic clk,
	input  wire logic miso,
	output logic      cs_n,
	output logic      sck,
	output logic      mosi
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// Mode 0, clock stands low outside frames
	task automatic xfer(input int n, input logic [31:0] w, output logic [7:0] rx);
		int i;
		@(negedge clk) cs_n = 1'b0;
		for (i = 0; i < n * 8; i++) begin
			mosi = w[31-i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			rx = {rx[6:0], miso};
			repeat (4) @(negedge clk);
			sck = 1'b0;
		end
		// Released line shows no stale data
		mosi = ~mosi;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		repeat (12) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import flash_wp_pkg::*;
	logic         clk, sys_rst, power_good, guard_n, scheme, cs_n, sck, mosi, miso_o, miso_oe, op_valid;
	array_op_type array_op;
	logic [7:0]   st1, st2, rx;
	int           err_count = 0, checked = 0, ops = 0;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	serial_flash_write_protect #(.POWERUP_DELAY_US(4), .PROGRAM_US(1), .SECTOR_ERASE_US(4),
		.CHIP_ERASE_US(1), .STATUS_WRITE_US(1)) u_dut (.clk(clk), .sys_rst(sys_rst), .power_good(power_good),
		.spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
		.write_guard_n(guard_n), .protect_scheme_select(scheme), .array_op(array_op),
		.array_op_valid(op_valid), .status_one(st1), .status_two(st2));
	// Undriven line shows the inverse, so a late enable garbles the reply
	spi_host_model host (.clk(clk), .miso(miso_oe ? miso_o : ~miso_o), .cs_n(cs_n), .sck(sck), .mosi(mosi));
	always @(posedge clk) if (op_valid) ops <= ops + 1;
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask
	task automatic idle;
		int k;
		for (k = 0; k < 400 && st1[BUSY_BIT] !== 1'b0; k++) @(negedge clk);
	endtask
	task automatic x(input int n, input logic [31:0] w);
		host.xfer(n, w, rx);
		idle();
	endtask
	task automatic wren;
		x(1, {CMD_WRITE_ENABLE, 24'h0});
	endtask
	task automatic ws(input logic [7:0] c, input logic [7:0] d);
		x(2, {c, d, 16'h0});
	endtask
	task automatic op(input logic [23:0] a, input int inc);
		int o;
		o = ops;
		wren();
		x(4, {CMD_SECTOR_ERASE, a});
		chk("ops", o + inc, ops);
	endtask
	task automatic pwr;
		power_good = 1'b0;
		repeat (8) @(negedge clk);
		power_good = 1'b1;
		repeat (4 * CLK_MHZ + 8) @(negedge clk);
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		sys_rst = 1'b1;
		power_good = 1'b1;
		guard_n = 1'b1;
		scheme = 1'b0;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		chk("status_one", 8'h00, st1);
		chk("status_two", 8'h00, st2);
		wren();
		chk("wel", 1'b0, st1[WEL_BIT]);
		repeat (40) @(negedge clk);
		x(4, {CMD_SECTOR_ERASE, 24'h0});
		chk("ops", 0, ops);
		wren();
		chk("wel", 1'b1, st1[WEL_BIT]);
		x(2, {CMD_READ_STATUS1, 24'h0});
		chk("miso", 8'h02, rx);
		host.xfer(4, {CMD_SECTOR_ERASE, 24'h0}, rx);
		chk("busy", 1'b1, st1[BUSY_BIT]);
		chk("kind", OP_SECTOR_ERASE, array_op.kind);
		host.xfer(1, {CMD_WRITE_DISABLE, 24'h0}, rx);
		chk("wel", 1'b1, st1[WEL_BIT]);
		idle();
		chk("status_one", 8'h00, st1);
		wren();
		ws(CMD_WRITE_STATUS1, 8'h04);
		chk("status_one", 8'h04, st1);
		op(24'h7f0000, 0);
		op(24'h000000, 1);
		wren();
		ws(CMD_WRITE_STATUS1, 8'h24);
		op(24'h000000, 0);
		op(24'h7f0000, 1);
		wren();
		ws(CMD_WRITE_STATUS1, 8'h44);
		op(24'h7ff000, 0);
		op(24'h7fe000, 1);
		wren();
		ws(CMD_WRITE_STATUS2, 8'h40);
		op(24'h7fe000, 0);
		op(24'h7ff000, 1);
		scheme = 1'b1;
		op(24'h010000, 0);
		wren();
		x(4, {CMD_UNLOCK, 24'h010000});
		op(24'h010000, 1);
		chk("addr", 24'h010000, array_op.addr);
		scheme = 1'b0;
		wren();
		ws(CMD_WRITE_STATUS1, 8'h80);
		guard_n = 1'b0;
		wren();
		ws(CMD_WRITE_STATUS1, 8'h84);
		chk("status_one", 8'h82, st1);
		guard_n = 1'b1;
		ws(CMD_WRITE_STATUS1, 8'h84);
		chk("status_one", 8'h84, st1);
		wren();
		ws(CMD_WRITE_STATUS2, 8'h02);
		guard_n = 1'b0;
		wren();
		ws(CMD_WRITE_STATUS1, 8'h88);
		chk("status_one", 8'h88, st1);
		wren();
		ws(CMD_WRITE_STATUS1, 8'h00);
		guard_n = 1'b0;
		wren();
		ws(CMD_WRITE_STATUS1, 8'h08);
		chk("status_one", 8'h08, st1);
		guard_n = 1'b1;
		wren();
		ws(CMD_WRITE_STATUS2, 8'h01);
		wren();
		ws(CMD_WRITE_STATUS1, 8'h00);
		chk("status_one", 8'h0a, st1);
		pwr();
		chk("status_two", 8'h00, st2);
		chk("status_one", 8'h08, st1);
		x(1, {CMD_POWER_DOWN, 24'h0});
		wren();
		chk("wel", 1'b0, st1[WEL_BIT]);
		x(1, {CMD_RELEASE_PD, 24'h0});
		wren();
		chk("wel", 1'b1, st1[WEL_BIT]);
		x(1, {CMD_OTP_KEY1, 24'h0});
		x(1, {CMD_OTP_KEY2, 24'h0});
		ws(CMD_WRITE_STATUS1, 8'h00);
		chk("status_two", 8'h01, st2);
		x(2, {CMD_READ_STATUS2, 24'h0});
		chk("miso", 8'h01, rx);
		pwr();
		wren();
		ws(CMD_WRITE_STATUS1, 8'h04);
		chk("status_one", 8'h02, st1);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: verilog/serial_flash_write_protect.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: Writes blocked during power-up delay window
// R2: Latch reads zero after power-up
// R3: Writes need latch set beforehand
// R4: Power-down ignores all but release
// R5: Lock bits per block and edge sector
// R6: Locked region ignores program and erase
// R7: Locks set at power-on; unlock clears
// R8: Scheme bit picks range or locks
// R9: Busy flag high during every operation
// R10: Busy ignores all but status reads; clears at finish
// R11: Write enable sets the latch
// R12: Latch cleared at power-up and completion
// R13: Range bits writable, zero means none
// R14: Top/bottom bit picks range end
// R15: Granule bit picks sector or block
// R16: Complement bit inverts protected range
// R17: Software mode ignores guard pin
// R18: Guarded mode refuses status writes, pin low
// R19: Guarded mode accepts writes, pin high
// R20: Lockdown refuses status writes until power cycle
// R21: Key prefix makes status lock permanent
// R22: Guard pin only outside quad mode
// R23: Quad enable disables guard pin
// R24: Refused instruction changes nothing
module serial_flash_write_protect #(
	parameter int POWERUP_DELAY_US = 5000,
	parameter int PROGRAM_US       = 4,
	parameter int SECTOR_ERASE_US  = 40,
	parameter int BLOCK_ERASE_US   = 150,
	parameter int CHIP_ERASE_US    = 1000,
	parameter int STATUS_WRITE_US  = 10
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic                     power_good,
	input  wire logic                     spi_cs_n,
	input  wire logic                     spi_sck,
	input  wire logic                     spi_mosi,
	output logic                          spi_miso_o,
	output logic                          spi_miso_oe,
	input  wire logic                     write_guard_n,
	input  wire logic                     protect_scheme_select,
	output var  flash_wp_pkg::array_op_type array_op,
	output logic                          array_op_valid,
	output logic [7:0]                    status_one,
	output logic [7:0]                    status_two
);
	import flash_wp_pkg::*;

	localparam int PUW_CYCLES    = POWERUP_DELAY_US * CLK_MHZ;
	localparam int PROG_CYCLES   = PROGRAM_US * CLK_MHZ;
	localparam int SECT_CYCLES   = SECTOR_ERASE_US * CLK_MHZ;
	localparam int BLOCK_CYCLES  = BLOCK_ERASE_US * CLK_MHZ;
	localparam int CHIP_CYCLES   = CHIP_ERASE_US * CLK_MHZ;
	localparam int STATUS_CYCLES = STATUS_WRITE_US * CLK_MHZ;
	localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(1);

	if (POWERUP_DELAY_US < 1 || PROGRAM_US < 1 || SECTOR_ERASE_US < 1 || BLOCK_ERASE_US < 1 ||
			CHIP_ERASE_US < 1 || STATUS_WRITE_US < 1) begin : bad_timing
		$error("Every operation time must be at least one microsecond");
	end

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_FIRST,
		KEY_ARMED
	} key_state_type;

	logic [1:0]              pg_sync_q;
	logic [1:0]              guard_sync_q;
	logic [1:0]              scheme_sync_q;
	logic                    power_off;
	frame_event_type         link;
	logic                    exec;
	logic [2:0]              byte_cnt_q;
	logic [7:0]              opcode_q;
	logic [ARG_W-1:0]        arg_q;
	logic                    rd_one_q;
	logic                    rd_two_q;
	logic [CNT_W-1:0]        puw_cnt_q;
	logic [CNT_W-1:0]        op_cnt_q;
	logic                    busy;
	logic                    wel_q;
	logic                    pd_q;
	logic [BP_W-1:0]         bp_q;
	logic                    tb_q;
	logic                    sec_q;
	logic                    srp_q;
	logic                    qe_q;
	logic                    cmp_q;
	logic                    srl_q;
	logic                    otp_q;
	key_state_type           key_q;
	logic [LOCK_BLOCKS-1:0]  block_lock_q;
	logic [SECTOR_LOCKS-1:0] sector_lock_q;

	logic                    ignored;
	logic                    write_gate;
	logic                    status_open;
	logic                    wren_ok;
	logic                    wrdi_ok;
	logic                    pd_enter;
	logic                    pd_leave;
	logic                    sr_ok;
	logic                    wr_s1;
	logic                    wr_s2;
	logic [7:0]              new_s1;
	logic [7:0]              new_s2;
	logic                    unlock_ok;
	logic                    op_ok;
	array_kind_type          op_kind;
	logic [CNT_W-1:0]        op_len;
	logic [ADDR_W-1:0]       addr;
	logic [ADDR_W-1:0]       blk_first;
	logic [ADDR_W-1:0]       blk_last;

	// Point check against the range bits
	function automatic logic range_hit(input logic [ADDR_W-1:0] a, input logic [BP_W-1:0] bp,
			input logic tb, input logic sec, input logic cmp);
		logic hit;
		int   k;
		hit = 1'b1;
		k   = 0;
		if (bp == BP_NONE) begin
			hit = 1'b0;
		end else if (bp != BP_ALL) begin
			if (sec) // R15
				k = SECTOR_SHIFT + int'((bp > BP_SEC_CAP) ? BP_SEC_CAP : bp) - 1;
			else
				k = ADDR_W - int'(BP_ALL) + int'(bp);
			for (int i = 0; i < ADDR_W; i++) begin
				if (i >= k && a[i] == tb) // R14
					hit = 1'b0;
			end
		end
		return hit ^ cmp; // R16
	endfunction

	// Lock check; whole covers all sectors of an edge block
	function automatic logic lock_hit(input logic [ADDR_W-1:0] a, input logic whole,
			input logic [LOCK_BLOCKS-1:0] blocks, input logic [SECTOR_LOCKS-1:0] sectors);
		logic [BLK_W-1:0] b;
		logic [3:0]       s;
		logic             hit;
		b = a[ADDR_W-1:BLOCK_SHIFT];
		s = a[BLOCK_SHIFT-1:SECTOR_SHIFT];
		if (b == '0)
			hit = whole ? |sectors[EDGE_SECTORS-1:0] : sectors[s];
		else if (b == BLK_W'(LOCK_BLOCKS + 1))
			hit = whole ? |sectors[SECTOR_LOCKS-1:EDGE_SECTORS] : sectors[EDGE_SECTORS + int'(s)];
		else
			hit = blocks[b - 1'b1];
		return hit;
	endfunction

	// Power-good pin, guard pin and scheme strap each pass two flops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pg_sync_q     <= '0;
			guard_sync_q  <= '0;
			scheme_sync_q <= '0;
		end else begin
			pg_sync_q     <= {pg_sync_q[0], power_good};
			guard_sync_q  <= {guard_sync_q[0], write_guard_n};
			scheme_sync_q <= {scheme_sync_q[0], protect_scheme_select};
		end
	end

	// Supply below threshold acts as reset of all volatile state
	assign power_off = sys_rst | ~pg_sync_q[1];

	spi_link_front u_front (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.spi_cs_n    (spi_cs_n),
		.spi_sck     (spi_sck),
		.spi_mosi    (spi_mosi),
		.tx_byte     (rd_two_q ? status_two : status_one),
		.tx_enable   (rd_one_q | rd_two_q),
		.link        (link),
		.spi_miso_o  (spi_miso_o),
		.spi_miso_oe (spi_miso_oe)
	);

	// Write instructions act only when chip select rises
	assign exec = link.stop & ~power_off;

	always_ff @(posedge clk) begin
		if (power_off) begin
			byte_cnt_q <= '0;
			opcode_q   <= '0;
			arg_q      <= '0;
		end else if (link.start) begin
			byte_cnt_q <= '0;
		end else if (link.byte_valid) begin
			if (byte_cnt_q == '0)
				opcode_q <= link.data;
			else if (byte_cnt_q < LEN_ADDR)
				arg_q <= {arg_q[ARG_W-BYTE_W-1:0], link.data};
			if (byte_cnt_q != LEN_SAT)
				byte_cnt_q <= byte_cnt_q + 1'b1;
		end
	end

	// Status reads stay served while busy
	always_ff @(posedge clk) begin
		if (power_off || link.start) begin
			rd_one_q <= 1'b0;
			rd_two_q <= 1'b0;
		end else if (link.byte_valid && byte_cnt_q == '0 && !pd_q) begin // R4
			rd_one_q <= (link.data == CMD_READ_STATUS1); // R10
			rd_two_q <= (link.data == CMD_READ_STATUS2);
		end
	end

	always_ff @(posedge clk) begin
		if (power_off)
			puw_cnt_q <= CNT_W'(PUW_CYCLES); // R1
		else if (puw_cnt_q != '0)
			puw_cnt_q <= puw_cnt_q - 1'b1;
	end

	assign addr      = arg_q[ADDR_W-1:0];
	assign blk_first = {addr[ADDR_W-1:BLOCK_SHIFT], {BLOCK_SHIFT{1'b0}}};
	assign blk_last  = {addr[ADDR_W-1:BLOCK_SHIFT], {BLOCK_SHIFT{1'b1}}};
	assign busy      = (op_cnt_q != '0);

	// Instruction acceptance
	always_comb begin
		ignored     = pd_q ? (opcode_q != CMD_RELEASE_PD) : busy; // R4 R10
		write_gate  = ~ignored & (puw_cnt_q == '0) & wel_q; // R1 R3
		status_open = ~srl_q & ~otp_q & ~(srp_q & ~qe_q & ~guard_sync_q[1]); // R17 R18 R19 R20 R21 R22 R23
		wren_ok     = (opcode_q == CMD_WRITE_ENABLE) & (byte_cnt_q == LEN_CMD) & ~ignored & (puw_cnt_q == '0); // R1
		wrdi_ok     = (opcode_q == CMD_WRITE_DISABLE) & (byte_cnt_q == LEN_CMD) & ~ignored;
		pd_enter    = (opcode_q == CMD_POWER_DOWN) & (byte_cnt_q == LEN_CMD) & ~ignored;
		pd_leave    = (opcode_q == CMD_RELEASE_PD) & pd_q;
		unlock_ok   = (opcode_q == CMD_UNLOCK) & (byte_cnt_q == LEN_ADDR) & write_gate; // R7
		wr_s1       = 1'b0;
		wr_s2       = 1'b0;
		new_s1      = arg_q[BYTE_W-1:0];
		new_s2      = arg_q[BYTE_W-1:0];
		if (opcode_q == CMD_WRITE_STATUS1 && byte_cnt_q == LEN_ONE_DATA) begin
			wr_s1 = 1'b1;
		end else if (opcode_q == CMD_WRITE_STATUS1 && byte_cnt_q == LEN_TWO_DATA) begin
			wr_s1  = 1'b1;
			wr_s2  = 1'b1;
			new_s1 = arg_q[2*BYTE_W-1:BYTE_W];
		end else if (opcode_q == CMD_WRITE_STATUS2 && byte_cnt_q == LEN_ONE_DATA) begin
			wr_s2 = 1'b1;
		end
		sr_ok   = (wr_s1 | wr_s2) & write_gate & status_open; // R3 R17
		op_kind = OP_NONE;
		op_len  = '0;
		op_ok   = 1'b0;
		case (opcode_q)
			CMD_PAGE_PROGRAM, CMD_QUAD_PROGRAM: begin
				op_kind = OP_PROGRAM;
				op_len  = CNT_W'(PROG_CYCLES);
				op_ok   = (byte_cnt_q >= LEN_PROG_MIN) & write_gate; // R3
				if (protect_scheme_select_level())
					op_ok = op_ok & ~lock_hit(addr, 1'b0, block_lock_q, sector_lock_q); // R6 R8
				else
					op_ok = op_ok & ~range_hit(addr, bp_q, tb_q, sec_q, cmp_q); // R8 R13
			end
			CMD_SECTOR_ERASE: begin
				op_kind = OP_SECTOR_ERASE;
				op_len  = CNT_W'(SECT_CYCLES);
				op_ok   = (byte_cnt_q == LEN_ADDR) & write_gate;
				if (protect_scheme_select_level())
					op_ok = op_ok & ~lock_hit(addr, 1'b0, block_lock_q, sector_lock_q); // R6
				else
					op_ok = op_ok & ~range_hit(addr, bp_q, tb_q, sec_q, cmp_q);
			end
			CMD_BLOCK32_ERASE, CMD_BLOCK64_ERASE: begin
				// Range is contiguous from an end, so both block ends cover any overlap
				op_kind = OP_BLOCK_ERASE;
				op_len  = CNT_W'(BLOCK_CYCLES);
				op_ok   = (byte_cnt_q == LEN_ADDR) & write_gate;
				if (protect_scheme_select_level())
					op_ok = op_ok & ~lock_hit(addr, 1'b1, block_lock_q, sector_lock_q); // R6
				else
					op_ok = op_ok & ~range_hit(blk_first, bp_q, tb_q, sec_q, cmp_q)
						& ~range_hit(blk_last, bp_q, tb_q, sec_q, cmp_q);
			end
			CMD_CHIP_ERASE, CMD_CHIP_ERASE_ALT: begin
				op_kind = OP_CHIP_ERASE;
				op_len  = CNT_W'(CHIP_CYCLES);
				op_ok   = (byte_cnt_q == LEN_CMD) & write_gate;
				if (protect_scheme_select_level())
					op_ok = op_ok & ~(|block_lock_q) & ~(|sector_lock_q);
				else
					op_ok = op_ok & (cmp_q ? (bp_q == BP_ALL) : (bp_q == BP_NONE));
			end
			CMD_SECREG_ERASE, CMD_SECREG_PROGRAM: begin
				op_kind = OP_SECREG;
				op_len  = CNT_W'(PROG_CYCLES);
				op_ok   = (byte_cnt_q >= LEN_ADDR) & write_gate;
			end
			default: begin
				if (sr_ok) begin
					op_kind = OP_STATUS_WRITE;
					op_len  = CNT_W'(STATUS_CYCLES);
					op_ok   = 1'b1;
				end
			end
		endcase
	end

	function automatic logic protect_scheme_select_level();
		return scheme_sync_q[1];
	endfunction

	// Operation timer; busy is its nonzero state
	always_ff @(posedge clk) begin
		if (power_off)
			op_cnt_q <= '0;
		else if (exec && op_ok)
			op_cnt_q <= op_len; // R9
		else if (busy)
			op_cnt_q <= op_cnt_q - 1'b1; // R10
	end

	always_ff @(posedge clk) begin
		if (power_off) begin
			array_op       <= '0;
			array_op_valid <= 1'b0;
		end else begin
			array_op_valid <= exec & op_ok; // R24
			if (exec && op_ok) begin
				array_op.kind <= op_kind;
				array_op.addr <= addr;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (power_off)
			wel_q <= 1'b0; // R2 R12
		else if (op_cnt_q == OP_LAST)
			wel_q <= 1'b0; // R12
		else if (exec && (wrdi_ok || unlock_ok))
			wel_q <= 1'b0; // R12
		else if (exec && wren_ok)
			wel_q <= 1'b1; // R11
	end

	always_ff @(posedge clk) begin
		if (power_off)
			pd_q <= 1'b0;
		else if (exec && pd_enter)
			pd_q <= 1'b1; // R4
		else if (exec && pd_leave)
			pd_q <= 1'b0;
	end

	// Non-volatile bits survive a power cycle; only sys_rst restores defaults
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bp_q  <= BP_NONE; // R13
			tb_q  <= 1'b0;
			sec_q <= 1'b0;
			srp_q <= 1'b0;
			qe_q  <= 1'b0;
			cmp_q <= 1'b0;
		end else if (exec && sr_ok) begin
			if (wr_s1) begin
				bp_q  <= new_s1[BP_LSB +: BP_W]; // R13
				tb_q  <= new_s1[TB_BIT];
				sec_q <= new_s1[SEC_BIT];
				srp_q <= new_s1[SRP_BIT];
			end
			if (wr_s2) begin
				qe_q  <= new_s2[QE_BIT];
				cmp_q <= new_s2[CMP_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (power_off)
			srl_q <= 1'b0; // R20
		else if (exec && sr_ok && wr_s2)
			srl_q <= new_s2[SRL_BIT];
	end

	// Key frames must be back to back and directly before the status write
	always_ff @(posedge clk) begin
		if (power_off) begin
			key_q <= KEY_IDLE;
		end else if (exec) begin
			case (key_q)
				KEY_IDLE:  key_q <= (opcode_q == CMD_OTP_KEY1 && byte_cnt_q == LEN_CMD) ? KEY_FIRST : KEY_IDLE;
				KEY_FIRST: key_q <= (opcode_q == CMD_OTP_KEY2 && byte_cnt_q == LEN_CMD) ? KEY_ARMED : KEY_IDLE;
				KEY_ARMED: key_q <= KEY_IDLE;
				default:   key_q <= KEY_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			otp_q <= 1'b0;
		else if (exec && sr_ok && key_q == KEY_ARMED)
			otp_q <= 1'b1; // R21
	end

	always_ff @(posedge clk) begin
		if (power_off) begin
			block_lock_q  <= '1; // R5 R7
			sector_lock_q <= '1;
		end else if (exec && unlock_ok) begin
			if (addr[ADDR_W-1:BLOCK_SHIFT] == '0)
				sector_lock_q[addr[BLOCK_SHIFT-1:SECTOR_SHIFT]] <= 1'b0; // R7
			else if (addr[ADDR_W-1:BLOCK_SHIFT] == BLK_W'(LOCK_BLOCKS + 1))
				sector_lock_q[EDGE_SECTORS + int'(addr[BLOCK_SHIFT-1:SECTOR_SHIFT])] <= 1'b0;
			else
				block_lock_q[addr[ADDR_W-1:BLOCK_SHIFT] - 1'b1] <= 1'b0;
		end
	end

	always_comb begin
		status_one                    = STATUS_RESET;
		status_one[BUSY_BIT]          = busy; // R9
		status_one[WEL_BIT]           = wel_q;
		status_one[BP_LSB +: BP_W]    = bp_q;
		status_one[TB_BIT]            = tb_q;
		status_one[SEC_BIT]           = sec_q;
		status_one[SRP_BIT]           = srp_q;
		status_two                    = STATUS_RESET;
		status_two[SRL_BIT]           = srl_q | otp_q;
		status_two[QE_BIT]            = qe_q;
		status_two[CMP_BIT]           = cmp_q;
	end

endmodule
`default_nettype wire

// file: verilog/spi_link_front.sv
`timescale 1ns/100ps
`default_nettype none
module spi_link_front (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       spi_cs_n,
	input  wire logic                       spi_sck,
	input  wire logic                       spi_mosi,
	input  wire logic [7:0]                 tx_byte,
	input  wire logic                       tx_enable,
	output var  flash_wp_pkg::frame_event_type link,
	output logic                            spi_miso_o,
	output logic                            spi_miso_oe
);
	import flash_wp_pkg::*;

	logic [1:0] cs_sync_q;
	logic [1:0] sck_sync_q;
	logic [1:0] mosi_sync_q;
	logic       cs_last_q;
	logic       sck_last_q;
	logic [2:0] bit_cnt_q;
	logic [6:0] rx_sh_q;
	logic [7:0] tx_sh_q;
	logic       load_q;
	logic       sck_rise;
	logic       sck_fall;

	// Pins pass two flops; stage zero feeds only stage one
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cs_sync_q   <= '1;
			sck_sync_q  <= '0;
			mosi_sync_q <= '0;
			cs_last_q   <= 1'b1;
			sck_last_q  <= 1'b0;
		end else begin
			cs_sync_q   <= {cs_sync_q[0], spi_cs_n};
			sck_sync_q  <= {sck_sync_q[0], spi_sck};
			mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
			cs_last_q   <= cs_sync_q[1];
			sck_last_q  <= sck_sync_q[1];
		end
	end

	assign sck_rise = sck_sync_q[1] & ~sck_last_q & ~cs_sync_q[1];
	assign sck_fall = ~sck_sync_q[1] & sck_last_q & ~cs_sync_q[1];

	// Input shifting on rising clock edges
	always_ff @(posedge clk) begin
		if (sys_rst || cs_sync_q[1]) begin
			bit_cnt_q <= '0;
			rx_sh_q   <= '0;
		end else if (sck_rise) begin
			bit_cnt_q <= bit_cnt_q + 1'b1;
			rx_sh_q   <= {rx_sh_q[5:0], mosi_sync_q[1]};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link   <= '0;
			load_q <= 1'b0;
		end else begin
			link.start      <= cs_last_q & ~cs_sync_q[1];
			link.stop       <= ~cs_last_q & cs_sync_q[1];
			link.byte_valid <= sck_rise & (bit_cnt_q == LAST_BIT);
			load_q          <= link.byte_valid;
			if (sck_rise && bit_cnt_q == LAST_BIT)
				link.data <= {rx_sh_q, mosi_sync_q[1]};
		end
	end

	// Reply byte loads a cycle after the byte, so the opcode has been decoded
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_sh_q    <= '0;
			spi_miso_o <= 1'b0;
		end else if (load_q) begin
			tx_sh_q <= tx_byte;
		end else if (sck_fall) begin
			spi_miso_o <= tx_sh_q[7];
			tx_sh_q    <= {tx_sh_q[6:0], 1'b0};
		end
	end

	assign spi_miso_oe = ~cs_sync_q[1] & tx_enable;

endmodule
`default_nettype wire
